// [bench/scr_receiver_assertions.sv]
// checker for the serial character receiver
`timescale 1ns/1ps
`default_nettype none
module scr_receiver_assertions #(parameter logic [5:0] SEL_CODE = 6'h00) (
  // watched ports
  input wire logic       i_clk_sys, i_rst_b, i_sel_en, i_io_clear,
  input wire logic       i_flag_sample, i_flag_clr2, i_xfer,
  input wire logic [5:0] i_sel_code,
  input wire logic [7:0] o_data,
  input wire logic       o_in_progress, o_flag, o_flag_gated, o_reader_run_n
);
  wire sel_ok = !i_sel_en || i_sel_code == SEL_CODE;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  a_run_low: assert property (i_flag_clr2 |=> !o_reader_run_n)
    else $error("run low");
  a_run_high: assert property (!i_flag_clr2 |=> o_reader_run_n)
    else $error("run high");
  a_gate_inv: assert property (!i_flag_sample |=> o_flag_gated)
    else $error("gate");
  a_gate_sel: assert property (!sel_ok |=> o_flag_gated)
    else $error("select");
  a_gate_on: assert property (
    i_flag_sample && sel_ok |=> !o_flag_gated) else $error("gate on");
  a_data_hold: assert property (
    !(i_xfer && sel_ok) && !i_io_clear |=> $stable(o_data))
    else $error("data");
  a_end_flag: assert property (
    $rose(o_flag) |-> $fell(o_in_progress))
    else $error("flag");
  a_clear_idle: assert property (i_io_clear |=> !o_in_progress)
    else $error("idle");
endmodule : scr_receiver_assertions
bind scr_receiver scr_receiver_assertions #(.SEL_CODE(SEL_CODE)) chk (.*);
`default_nettype wire

// [bench/scr_receiver_tb.sv]
// receiver bench
`timescale 1ns/1ps
`default_nettype none
module scr_receiver_tb;
  logic        i_clk_sys = 1'b0, i_rst_b = 1'b0, i_io_clear = 1'b1;
  logic        i_eight_bit = 1'b0, i_sel_en = 1'b0, i_flag_sample = 1'b0;
  logic        i_flag_clr1 = 1'b0, i_flag_clr2 = 1'b0, i_xfer = 1'b0;
  logic        i_serial, i_baud_x2, o_in_progress, o_in_progress_n, ok;
  logic        o_flag, o_flag_gated, o_reader_run_n;
  logic [1:0]  i_stop_sel = 2'h0;
  logic [5:0]  i_sel_code = 6'h00;
  logic [7:0]  o_data, ex = 8'h00;
  logic [31:0] rs = 32'h8850_7485;
  int          fail_count = 0, tests_run = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  scr_sender scr_sender_inst (.o_baud_x2(i_baud_x2), .o_serial(i_serial));
  scr_receiver #(.SEL_CODE(6'h2a)) scr_receiver_inst (.*);
  function automatic logic [31:0] nx(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : nx
  task automatic chk(input logic [9:0] s, input logic [9:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %0t %h %h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim;
    $display("fails %0d of %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (4) @(negedge i_clk_sys);
    i_rst_b = 1'b1;
    scr_sender_inst.hold(1'b1, 1);
    i_io_clear = 1'b0;
    scr_sender_inst.hold(1'b0, 1);
    scr_sender_inst.hold(1'b1, 4);
    chk({o_in_progress, o_flag}, 2'b00);
    for (int k = 0; k < 14; k++) begin
      rs = nx(rs);
      {i_eight_bit, i_sel_en, i_flag_sample} = rs[10:8];
      i_stop_sel = 2'(k % 3);
      i_sel_code = {rs[11], 5'h0a};
      ok = !i_sel_en || rs[11];
      i_flag_clr2 = 1'b1;
      @(negedge i_clk_sys);
      chk({o_reader_run_n, o_flag}, 2'b00);
      i_flag_clr2 = 1'b0;
      scr_sender_inst.send(rs[7:0], i_eight_bit ? 8 : 5, i_stop_sel + 2);
      chk({o_in_progress, o_in_progress_n}, 2'b01);
      if (ok) ex = i_eight_bit ? rs[7:0] : {3'h0, rs[4:0]};
      ok = !(i_flag_sample && ok);
      i_xfer = 1'b1;
      @(negedge i_clk_sys);
      i_xfer = 1'b0;
      chk({o_flag, o_flag_gated, o_data}, {1'b1, ok, ex});
    end
    end_sim();
  end
endmodule : scr_receiver_tb
`default_nettype wire

// [bench/scr_sender.sv]
// serial sender model with half-unit clock
`timescale 1ns/1ps
`default_nettype none
module scr_sender (
  // line out
  output logic o_baud_x2,
  output logic o_serial
);
  initial {o_baud_x2, o_serial} = 2'b01;
  always #10 o_baud_x2 = ~o_baud_x2;
  task automatic hold(input logic v, input int n);
    o_serial = v;
    repeat (n) @(negedge o_baud_x2);
  endtask : hold
  task automatic send(input logic [7:0] ch, input int nb, input int hs);
    @(negedge o_baud_x2);
    hold(1'b0, 2);
    for (int i = 0; i < nb; i++) hold(ch[i], 2);
    hold(1'b1, hs);
  endtask : send
endmodule : scr_sender
`default_nettype wire

// [design/scr_pkg.sv]
// types for the serial character receiver
package scr_pkg;
  typedef enum logic [3:0] {
    SCR_IDLE  = 4'b0001,
    SCR_START = 4'b0010,
    SCR_DATA  = 4'b0100,
    SCR_STOP  = 4'b1000
  } scr_state_t;
endpackage : scr_pkg

// [design/scr_receiver.sv]
// serial character receiver: serial to parallel with select and pacing
// What this block does
// - assemble 5- or 8-bit serial characters, deliver parallel on command
// - 5-bit frames of 7.0, 7.5 or 8.0 units by strap
// - 8-bit frames of 10.0, 10.5 or 11.0 units by strap
// - stop interval strap selects 1.0, 1.5 or 2 units
// - start pulse not longer than half unit is ignored
// - device-select decoding gates transfer, flag-sample and first flag-clear; standalone mode bypasses it
// - high second flag-clear drives reader-run request low
// - gated flag output high while flag sample request is low
// - character-in-progress drops when the last data bit arrives
// - transfer command places assembled register on parallel outputs
`timescale 1ns/1ps
`default_nettype none
`include "scr_regs.svh"
module scr_receiver
  import scr_pkg::*;
#(
  parameter logic [5:0] SEL_CODE = 6'h00
) (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  // line and bit-rate clock
  input  wire logic       i_serial,
  input  wire logic       i_baud_x2,
  // straps
  input  wire logic       i_eight_bit,
  input  wire logic [1:0] i_stop_sel,
  // device select
  input  wire logic       i_sel_en,
  input  wire logic [5:0] i_sel_code,
  // control inputs
  input  wire logic       i_io_clear,
  input  wire logic       i_flag_sample,
  input  wire logic       i_flag_clr1,
  input  wire logic       i_flag_clr2,
  input  wire logic       i_xfer,
  // outputs
  output logic [7:0]      o_data,
  output logic            o_in_progress,
  output logic            o_in_progress_n,
  output logic            o_flag,
  output logic            o_flag_gated,
  output logic            o_reader_run_n
);
  scr_state_t state_q, state_d;
  logic [3:0] half_q, half_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] shift_q, shift_d;
  logic       tick;
  logic       flag_q;

  // half-unit tick from the bit-rate clock
  scr_sync_edge u_tick (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_level   (i_baud_x2),
    .o_rise    (tick)
  );

  // select passes when disabled or matched
  wire       sel_ok  = ~i_sel_en | (i_sel_code == SEL_CODE);
  wire [3:0] nbits   = i_eight_bit ? `SCR_BITS_8 : `SCR_BITS_5;
  wire [3:0] stop_h  = (i_stop_sel == `SCR_STOP_1_5) ? `SCR_STOP_HALVES_15 :
                       (i_stop_sel == `SCR_STOP_2_0) ? `SCR_STOP_HALVES_20 :
                       `SCR_STOP_HALVES_10;
  wire       last_b  = (bit_q == nbits - 4'h1);
  wire       mid_smp = tick & half_q[0];
  wire       done_ch = (state_q == SCR_DATA) & mid_smp & last_b;

  // next state, counters and shifter
  always_comb begin
    state_d = state_q;
    half_d  = half_q;
    bit_d   = bit_q;
    shift_d = shift_q;
    case (state_q)
      // wait for the line to drop at a tick
      SCR_IDLE: begin
        half_d = 4'h0;
        bit_d  = 4'h0;
        if (tick && !i_serial) begin
          state_d = SCR_START;
        end
      end

      // start must still be low one tick later
      SCR_START: begin
        if (tick) begin
          if (i_serial) begin
            state_d = SCR_IDLE;
          end else if (half_q == `SCR_START_HALVES) begin
            state_d = SCR_DATA;
            half_d  = 4'h0;
          end else begin
            half_d = half_q + 4'h1;
          end
        end
      end

      // sample on odd ticks, near mid-bit
      SCR_DATA: begin
        if (tick) begin
          half_d = half_q + 4'h1;
          if (half_q[0]) begin
            shift_d = {i_serial, shift_q[7:1]};
            bit_d   = bit_q + 4'h1;
            if (last_b) begin
              state_d = SCR_STOP;
              half_d  = 4'h0;
            end
          end
        end
      end

      // let the stop interval pass
      SCR_STOP: begin
        if (tick) begin
          half_d = half_q + 4'h1;
          if (half_q + 4'h1 >= stop_h) begin
            state_d = SCR_IDLE;
          end
        end
      end
      default: state_d = SCR_IDLE;
    endcase
    if (i_io_clear) begin
      state_d = SCR_IDLE;
    end
  end

  // 5-bit characters land right-justified
  wire [7:0] aligned = i_eight_bit ? shift_q : {3'h0, shift_q[7:3]};
  wire       clr1    = i_flag_clr1 & sel_ok;
  wire       flag_d  = done_ch | (flag_q & ~clr1 & ~i_flag_clr2);
  wire       busy_d  = (state_d == SCR_START) |
                       (state_d == SCR_DATA);
  wire       xfer_ok = i_xfer & sel_ok;
  wire       smp_ok  = i_flag_sample & sel_ok;

  // frame state
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= SCR_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // half-tick and bit counters
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      half_q <= 4'h0;
      bit_q  <= 4'h0;
    end else begin
      half_q <= half_d;
      bit_q  <= bit_d;
    end
  end

  // receive shifter
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift_q <= `SCR_DATA_RST;
    end else begin
      shift_q <= shift_d;
    end
  end

  // sticky done flag, set beats clear
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flag_q <= 1'b0;
      o_flag <= 1'b0;
    end else begin
      flag_q <= flag_d;
      o_flag <= flag_d;
    end
  end

  // parallel register, loaded on a selected transfer
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_data <= `SCR_DATA_RST;
    end else if (xfer_ok) begin
      o_data <= aligned;
    end
  end

  // in progress and its inverse for transmitter hold
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_in_progress   <= 1'b0;
      o_in_progress_n <= 1'b1;
    end else begin
      o_in_progress   <= busy_d;
      o_in_progress_n <= ~busy_d;
    end
  end

  // strobe gate and reader pacing
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_flag_gated   <= 1'b0;
      o_reader_run_n <= 1'b1;
    end else begin
      o_flag_gated   <= ~smp_ok;
      o_reader_run_n <= ~i_flag_clr2;
    end
  end
endmodule : scr_receiver
`default_nettype wire

// [design/scr_regs.svh]
// constants for the serial character receiver
`ifndef SCR_REGS_SVH
`define SCR_REGS_SVH
`define SCR_BITS_5         4'h5
`define SCR_BITS_8         4'h8
`define SCR_STOP_1_0       2'h0
`define SCR_STOP_1_5       2'h1
`define SCR_STOP_2_0       2'h2
`define SCR_START_HALVES   4'h0
`define SCR_STOP_HALVES_10 4'h2
`define SCR_STOP_HALVES_15 4'h3
`define SCR_STOP_HALVES_20 4'h4
`define SCR_DATA_RST       8'h00
`endif

// [design/scr_sync_edge.sv]
// rising-edge detector for the twice-bit-rate (half-unit) timing clock input
`timescale 1ns/1ps
`default_nettype none
module scr_sync_edge (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst_b,
  // level in, pulse out
  input  wire logic i_level,
  output logic      o_rise
);
  logic lvl_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lvl_q <= 1'b0;
    end else begin
      lvl_q <= i_level;
    end
  end

  assign o_rise = i_level & ~lvl_q;
endmodule : scr_sync_edge
`default_nettype wire
